// ==== logic/ric_pkg.sv ====
// Purpose: Shared constants
// Assumes: One CPU clock
// Notes: 13-bit vector addresses
//
// Functional notes
// [R1] Two reset sources; watchdog resets via pin
// [R2] Outside reset held at least 1.5 cycles
// [R3] Any reset loads PC from top vector
// [R4] Power-up holds reset 4096 cycles, pin extends
// [R5] Drive reset pin low during power-on reset
// [R6] Entry pushes PC, X, A, CC; sets mask
// [R7] Return clears mask only if stacked zero
// [R8] Fixed priority; masked means trap only
// [R9] Trap always enters regardless of mask
// [R10] External pin serviced only when unmasked
// [R11] Two select bits give four trigger modes
// [R12] Select writes ignored unmasked; change drops pending
// [R13] Interrupts taken only at instruction boundaries
// [R14] Masked edges latched; low level not latched
// [R15] Pending latch cleared at service start
// [R16] Pulse spacing: service cycles plus 21
// [R17] Level mode re-triggers if line stays low
// [R18] Wake-up falls on enabled pins raise request
// [R19] Resets preset timer, ports, stack, mask, latches
// [R20] Resets and stop clear slow, watchdog bits
// [R21] Power-on and stop gate clocks 4096 cycles
// [R22] Rise select bit 6, fall select bit 5
// [R23] Each source owns a descending vector pair
// [R24] Pull-downs merged; pin synchronised before release
package ric_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned POR_CYCLES = 4096;  // Start-up hold
  localparam int unsigned IRQ_GAP_EXTRA = 21;  // Pulse gap extra

  // ****************************************
  // Vector addresses
  // ****************************************
  localparam logic [12:0] VEC_RESET = 13'h1FFE;  // Reset
  localparam logic [12:0] VEC_TRAP = 13'h1FFC;  // Software trap
  localparam logic [12:0] VEC_EXT = 13'h1FFA;  // External pin
  localparam logic [12:0] VEC_ICAP = 13'h1FF8;  // Timer input capture
  localparam logic [12:0] VEC_OCMP = 13'h1FF6;  // Timer output compare
  localparam logic [12:0] VEC_TOVF = 13'h1FF4;  // Timer overflow
  localparam logic [12:0] VEC_WAKE = 13'h1FF0;  // Wake-up port

  // ****************************************
  // Reset values and field positions
  // ****************************************
  localparam logic [15:0] TIMER_PRESET = 16'hFFFC;  // Timer preset
  localparam logic [7:0] SP_RESET = 8'hFF;  // SP preset
  localparam int unsigned MISC_RISE_BIT = 6;  // Rise select position
  localparam int unsigned MISC_FALL_BIT = 5;  // Fall select position
  localparam logic [1:0] TRIG_RESET = 2'h0;  // Select bits after reset
  localparam int unsigned WAKE_PINS = 6;  // Wake-up pin count

  // Trigger modes, coded as {rise, fall}
  typedef enum logic [1:0] {
    RIC_TRIG_FALL_LOW = 2'b00,
    RIC_TRIG_FALL = 2'b01,
    RIC_TRIG_RISE = 2'b10,
    RIC_TRIG_BOTH = 2'b11
  } ric_trig_t;

  // Source index in priority order, trap first
  typedef enum logic [2:0] {
    RIC_SRC_TRAP = 3'b000,
    RIC_SRC_EXT = 3'b001,
    RIC_SRC_ICAP = 3'b010,
    RIC_SRC_OCMP = 3'b011,
    RIC_SRC_TOVF = 3'b100,
    RIC_SRC_WAKE = 3'b101,
    RIC_SRC_NONE = 3'b110
  } ric_src_t;

endpackage

// ==== logic/ric_reset_gen.sv ====
// Purpose: Reset sequencing
// Assumes: sys_rst marks power-up
// Notes: Internal reset released only after pin seen high through sync
`timescale 1ns/10ps
module ric_reset_gen #(
  parameter int unsigned POR_COUNT = ric_pkg::POR_CYCLES  // Start-up hold
) (
  input wire logic clk_sys,  // CPU clock
  input wire logic sys_rst,  // Power-up detect, sync active high
  input wire logic rst_pin_i,  // Reset pin level, async
  input wire logic watchdog_kick_bit_rst_req,  // Watchdog timeout pulse or level
  output logic rst_pin_o,  // Pin drive value, always low
  output logic rst_pin_oe,  // Pin pulled low while high
  output logic cpu_rst,  // Internal reset to the core
  output logic por_active  // Power-on hold running
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [1:0] pin_sync;  // Pin synchroniser
    logic [12:0] por_cnt;  // Power-on counter
    logic por_act;  // Power-on in progress
    logic wd_drive;  // Watchdog pull-down stretch
    logic rst;  // Internal reset
  } ric_rg_t;

  ric_rg_t s_q;
  ric_rg_t s_d;

  // Next-state logic
  always_comb
  begin
    s_d = s_q;
    s_d.pin_sync = {s_q.pin_sync[0], rst_pin_i};  // [R24]
    // Count power-on hold, then release
    if (s_q.por_act)
    begin
      if (s_q.por_cnt == 13'(POR_COUNT - 1))
        s_d.por_act = 1'b0;  // [R4]
      else
        s_d.por_cnt = s_q.por_cnt + 13'h0001;
    end
    // Watchdog reset pulls the pin; held until pin seen low so it lasts >1.5 cycles
    if (watchdog_kick_bit_rst_req)
      s_d.wd_drive = 1'b1;  // [R1]
    else if (!s_q.pin_sync[1])
      s_d.wd_drive = 1'b0;
    // Reset held while POR runs or pin low
    s_d.rst = s_q.por_act || !s_q.pin_sync[1] || s_q.wd_drive;  // [R4] [R24]
  end

  // State register
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      s_q.pin_sync <= 2'h0;
      s_q.por_cnt <= 13'h0000;
      s_q.por_act <= 1'b1;
      s_q.wd_drive <= 1'b0;
      s_q.rst <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  // Open-drain: only low is ever driven
  assign rst_pin_o = 1'b0;
  assign rst_pin_oe = s_q.por_act || s_q.wd_drive;  // [R5] [R1] [R24]
  assign cpu_rst = s_q.rst;
  assign por_active = s_q.por_act;  // [R21]

endmodule

// ==== logic/ric_ext_trig.sv ====
// Purpose: External pin trigger
// Assumes: Pin already synchronised by the caller
// Notes: Level request is live only, never latched
`timescale 1ns/10ps
module ric_ext_trig (
  input wire logic clk_sys,  // CPU clock
  input wire logic sys_rst,  // Sync reset
  input wire logic pin_s,  // Synchronised pin level
  input wire logic [1:0] trig_mode,  // {rise, fall} select
  input wire logic mode_change,  // Select bits changed, drop pending
  input wire logic clear,  // Service started
  output logic ext_req  // Request to arbiter
);

  typedef struct packed {
    logic prev;  // Pin last cycle
    logic pend;  // Edge latch
  } ric_et_t;

  ric_et_t s_q;
  ric_et_t s_d;
  logic rise;
  logic fall;
  logic edge_hit;

  // Edge decode per mode
  always_comb
  begin
    rise = pin_s && !s_q.prev;
    fall = !pin_s && s_q.prev;
    unique case (ric_pkg::ric_trig_t'(trig_mode))  // [R11]
      ric_pkg::RIC_TRIG_FALL_LOW: edge_hit = fall;
      ric_pkg::RIC_TRIG_FALL: edge_hit = fall;
      ric_pkg::RIC_TRIG_RISE: edge_hit = rise;
      ric_pkg::RIC_TRIG_BOTH: edge_hit = rise || fall;
    endcase
    s_d.prev = pin_s;
    // Set beats clear; a mode change always discards
    if (mode_change)
      s_d.pend = 1'b0;  // [R12]
    else if (edge_hit)
      s_d.pend = 1'b1;  // [R14]
    else if (clear)
      s_d.pend = 1'b0;  // [R15]
    else
      s_d.pend = s_q.pend;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      s_q.prev <= 1'b1;
      s_q.pend <= 1'b0;  // [R19]
    end
    else
      s_q <= s_d;
  end

  // Low level adds a live request in mode 00 so a held-low line retriggers
  assign ext_req = s_q.pend ||
    ((ric_pkg::ric_trig_t'(trig_mode) == ric_pkg::RIC_TRIG_FALL_LOW) && !pin_s);  // [R17]

endmodule

// ==== logic/ric_top.sv ====
// Purpose: Reset and interrupt control for an 8-bit controller core
// Assumes: Core marks boundaries
// Notes: One push per cycle
`timescale 1ns/10ps
module ric_top (
  input wire logic clk_sys,  // Clock
  input wire logic sys_rst,  // Power-up
  input wire logic rst_pin_i,  // Pin in
  output logic rst_pin_o,  // Pin value
  output logic rst_pin_oe,  // Pin pull
  input wire logic watchdog_kick_bit_rst_req,  // Watchdog
  output logic cpu_rst,  // Core reset
  input wire logic ext_irq_pin,  // Irq pin
  input wire logic [5:0] wakeup_pins,  // Wake pins
  input wire logic [5:0] wakeup_irq_en,  // Wake enables
  input wire logic tmr_icap_irq,  // Capture
  input wire logic tmr_ocmp_irq,  // Compare
  input wire logic tmr_tovf_irq,  // Overflow
  input wire logic trap_exec,  // Trap
  input wire logic instr_done,  // Boundary
  input wire logic irq_return_instruction,  // Return
  input wire logic [7:0] stack_cc_byte,  // Popped codes
  input wire logic [15:0] program_counter,  // Prog counter
  input wire logic [7:0] x_reg,  // X
  input wire logic [7:0] acc_reg,  // A
  input wire logic [7:0] cond_code_reg,  // Codes
  input wire logic misc_wr,  // Misc write
  input wire logic [7:0] misc_wdata,  // Misc data
  input wire logic halt_enter,  // Stop entry
  input wire logic wait_enter,  // Wait entry
  input wire logic [7:0] stack_ptr_i,  // Stack ptr
  output logic push_valid,  // Push
  output logic [7:0] push_data,  // Push byte
  output logic [7:0] push_sp,  // Push addr
  output logic pc_load,  // Vector load
  output logic [12:0] vector_addr,  // Vector
  output logic irq_busy,  // Entry busy
  output logic irq_mask,  // Mask
  output logic ext_irq_rise_select,  // Rise sel
  output logic ext_irq_fall_select,  // Fall sel
  output logic slow_clock_select,  // Slow
  output logic watchdog_kick_bit,  // Watchdog_kick_bit en
  output logic watchdog_kick_bit_cnt_clr,  // Watchdog_kick_bit clear
  output logic [15:0] tmr_preset,  // Timer preset
  output logic tmr_reset,  // Timer clear
  output logic port_dir_clr,  // Dir clear
  output logic store_ctl_clr,  // Store clear
  output logic [7:0] sp_reset_val,  // SP value
  output logic sp_load,  // SP load
  output logic cpu_clk_en,  // CPU gate
  output logic timer_clk_en,  // Timer gate
  output logic halt_latch,  // Stop latch
  output logic wait_latch  // Wait latch
);

  // ****************************************
  // Types and state
  // ****************************************
  typedef enum logic [2:0] {
    RIC_ST_RUN = 3'b000,
    RIC_ST_PCL = 3'b001,
    RIC_ST_PCH = 3'b010,
    RIC_ST_X = 3'b011,
    RIC_ST_A = 3'b100,
    RIC_ST_CC = 3'b101,
    RIC_ST_VEC = 3'b110
  } ric_state_t;

  typedef struct packed {
    ric_state_t st;  // Sequencer
    ric_pkg::ric_src_t src;  // Source
    logic [7:0] sp;  // Push address
    logic [7:0] cc_save;  // Saved codes
    logic [15:0] pc_save;  // PC snapshot
    logic [7:0] x_save;  // X snapshot
    logic [7:0] a_save;  // A snapshot
    logic mask;  // Interrupt mask
    logic [1:0] trig;  // {rise, fall} select
    logic slow;  // Slow clock select
    logic watchdog_kick_bit_en;  // Watchdog enable
    logic halt;  // Stop latch
    logic waitl;  // Wait latch
    logic [12:0] stop_cnt;  // Stop delay
    logic stop_gate;  // Stop gate
    logic [5:0] wk_prev;  // Wake pins last cycle
    logic wk_pend;  // Wake-up request latch
    logic rst_d1;  // Reset one cycle ago
    logic boot;  // Boot fetch
  } ric_top_t;

  ric_top_t s_q;
  ric_top_t s_d;

  logic [1:0] ext_sync_q;  // External pin synchroniser
  logic [5:0] wk_s1_q;  // Wake pins first stage
  logic [5:0] wk_s2_q;  // Wake pins second stage
  logic ext_req;
  logic ext_clear;
  logic mode_change;
  logic por_active;
  logic [1:0] trig_wr;
  ric_pkg::ric_src_t pick;

  // Priority pick among pending sources
  function automatic ric_pkg::ric_src_t ric_pick(input logic trap, input logic masked,
      input logic ext, input logic icap, input logic ocmp, input logic tovf, input logic wake);
    if (trap)
      return ric_pkg::RIC_SRC_TRAP;  // [R9]
    else if (masked)
      return ric_pkg::RIC_SRC_NONE;  // [R8] [R10]
    else if (ext)
      return ric_pkg::RIC_SRC_EXT;
    else if (icap)
      return ric_pkg::RIC_SRC_ICAP;
    else if (ocmp)
      return ric_pkg::RIC_SRC_OCMP;
    else if (tovf)
      return ric_pkg::RIC_SRC_TOVF;
    else if (wake)
      return ric_pkg::RIC_SRC_WAKE;
    else
      return ric_pkg::RIC_SRC_NONE;
  endfunction

  // Vector table lookup
  function automatic logic [12:0] ric_vec(input ric_pkg::ric_src_t src);
    unique case (src)  // [R23]
      ric_pkg::RIC_SRC_TRAP: return ric_pkg::VEC_TRAP;
      ric_pkg::RIC_SRC_EXT: return ric_pkg::VEC_EXT;
      ric_pkg::RIC_SRC_ICAP: return ric_pkg::VEC_ICAP;
      ric_pkg::RIC_SRC_OCMP: return ric_pkg::VEC_OCMP;
      ric_pkg::RIC_SRC_TOVF: return ric_pkg::VEC_TOVF;
      ric_pkg::RIC_SRC_WAKE: return ric_pkg::VEC_WAKE;
      default: return ric_pkg::VEC_RESET;
    endcase
  endfunction

  // ****************************************
  // Reset sequencing
  // ****************************************
  ric_reset_gen u_rst (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .rst_pin_i(rst_pin_i),
    .watchdog_kick_bit_rst_req(watchdog_kick_bit_rst_req || (halt_enter && s_q.watchdog_kick_bit_en)),
    .rst_pin_o(rst_pin_o),
    .rst_pin_oe(rst_pin_oe),
    .cpu_rst(cpu_rst),
    .por_active(por_active)
  );

  // Input synchronisers for pins
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      ext_sync_q <= 2'h3;
      wk_s1_q <= 6'h3F;
      wk_s2_q <= 6'h3F;
    end
    else
    begin
      ext_sync_q <= {ext_sync_q[0], ext_irq_pin};
      wk_s1_q <= wakeup_pins;
      wk_s2_q <= wk_s1_q;
    end
  end

  // ****************************************
  // External pin trigger
  // ****************************************
  assign trig_wr = {misc_wdata[ric_pkg::MISC_RISE_BIT], misc_wdata[ric_pkg::MISC_FALL_BIT]};  // [R22]
  // Accepted only while masked, and only a real change drops pending
  assign mode_change = misc_wr && s_q.mask && (trig_wr != s_q.trig);  // [R12]
  assign ext_clear = (s_q.st == RIC_ST_PCL) && (s_q.src == ric_pkg::RIC_SRC_EXT);  // [R15]

  ric_ext_trig u_ext (
    .clk_sys(clk_sys),
    .sys_rst(cpu_rst),
    .pin_s(ext_sync_q[1]),
    .trig_mode(s_q.trig),
    .mode_change(mode_change),
    .clear(ext_clear),
    .ext_req(ext_req)
  );

  assign pick = ric_pick(trap_exec, s_q.mask, ext_req, tmr_icap_irq, tmr_ocmp_irq,
    tmr_tovf_irq, s_q.wk_pend);  // [R8]

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb
  begin
    s_d = s_q;
    s_d.rst_d1 = cpu_rst;
    s_d.wk_prev = wk_s2_q;
    // Wake-up falling edge on enabled pin; set wins over clear
    if (|(s_q.wk_prev & ~wk_s2_q & wakeup_irq_en))
      s_d.wk_pend = 1'b1;  // [R18]
    else if (s_q.st == RIC_ST_PCL && s_q.src == ric_pkg::RIC_SRC_WAKE)
      s_d.wk_pend = 1'b0;
    // Trigger select write
    if (mode_change)
      s_d.trig = trig_wr;  // [R12]
    if (misc_wr)
    begin
      s_d.slow = misc_wdata[1];
      if (misc_wdata[0])
        s_d.watchdog_kick_bit_en = 1'b1;  // Only reset clears it; stop entry with it set requests a reset
    end
    // Wait entry clears mask; stop entry with watchdog off also clears mask, slow and watchdog
    if (wait_enter)
    begin
      s_d.waitl = 1'b1;
      s_d.mask = 1'b0;  // [R20]
    end
    if (halt_enter && !s_q.watchdog_kick_bit_en)
    begin
      s_d.halt = 1'b1;
      s_d.mask = 1'b0;  // [R20]
      s_d.slow = 1'b0;
      s_d.watchdog_kick_bit_en = 1'b0;
    end
    // Stop wake starts the restart delay
    if (s_q.halt && (ext_req || s_q.wk_pend))
    begin
      s_d.halt = 1'b0;
      s_d.stop_gate = 1'b1;
      s_d.stop_cnt = 13'h0000;
    end
    if (s_q.stop_gate)
    begin
      if (s_q.stop_cnt == 13'(ric_pkg::POR_CYCLES - 1))
        s_d.stop_gate = 1'b0;  // [R21]
      else
        s_d.stop_cnt = s_q.stop_cnt + 13'h0001;
    end
    // Reset vector fetched once reset releases
    if (s_q.rst_d1 && !cpu_rst)
      s_d.boot = 1'b1;  // [R3]
    else if (s_q.boot)
      s_d.boot = 1'b0;
    // Entry sequencer: one push per cycle
    unique case (s_q.st)
      RIC_ST_RUN:
      begin
        if (instr_done && pick != ric_pkg::RIC_SRC_NONE && !s_q.stop_gate && !s_q.boot)
        begin
          s_d.st = RIC_ST_PCL;  // [R13]
          s_d.src = pick;
          s_d.sp = stack_ptr_i;
          s_d.pc_save = program_counter;
          s_d.x_save = x_reg;
          s_d.a_save = acc_reg;
          s_d.cc_save = cond_code_reg;
          s_d.waitl = 1'b0;
        end
        else if (irq_return_instruction)
          s_d.mask = stack_cc_byte[3];  // [R7]
      end
      RIC_ST_PCL:
      begin
        s_d.st = RIC_ST_PCH;  // [R6]
        s_d.sp = s_q.sp - 8'h01;
      end
      RIC_ST_PCH:
      begin
        s_d.st = RIC_ST_X;
        s_d.sp = s_q.sp - 8'h01;
      end
      RIC_ST_X:
      begin
        s_d.st = RIC_ST_A;
        s_d.sp = s_q.sp - 8'h01;
      end
      RIC_ST_A:
      begin
        s_d.st = RIC_ST_CC;
        s_d.sp = s_q.sp - 8'h01;
      end
      RIC_ST_CC:
      begin
        s_d.st = RIC_ST_VEC;
        s_d.mask = 1'b1;  // [R6]
        s_d.sp = s_q.sp - 8'h01;
      end
      RIC_ST_VEC:
        s_d.st = RIC_ST_RUN;
      default:
        s_d.st = RIC_ST_RUN;
    endcase
  end

  // State register, cleared by either reset type
  always_ff @(posedge clk_sys)
  begin
    if (cpu_rst)
    begin
      s_q <= '0;
      s_q.st <= RIC_ST_RUN;  // [R19]
      s_q.src <= ric_pkg::RIC_SRC_NONE;
      s_q.sp <= ric_pkg::SP_RESET;
      s_q.mask <= 1'b1;  // [R19]
      s_q.trig <= ric_pkg::TRIG_RESET;
      s_q.wk_prev <= 6'h3F;
      s_q.rst_d1 <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_comb
  begin
    push_valid = (s_q.st != RIC_ST_RUN) && (s_q.st != RIC_ST_VEC);
    unique case (s_q.st)
      RIC_ST_PCL: push_data = s_q.pc_save[7:0];
      RIC_ST_PCH: push_data = s_q.pc_save[15:8];
      RIC_ST_X: push_data = s_q.x_save;
      RIC_ST_A: push_data = s_q.a_save;
      RIC_ST_CC: push_data = s_q.cc_save;
      default: push_data = 8'h00;
    endcase
  end

  assign push_sp = s_q.sp;
  assign pc_load = s_q.boot || (s_q.st == RIC_ST_VEC);  // [R3]
  assign vector_addr = s_q.boot ? ric_pkg::VEC_RESET : ric_vec(s_q.src);
  assign irq_busy = (s_q.st != RIC_ST_RUN);
  assign irq_mask = s_q.mask;
  assign ext_irq_rise_select = s_q.trig[1];
  assign ext_irq_fall_select = s_q.trig[0];
  assign slow_clock_select = s_q.slow;  // [R20]
  assign watchdog_kick_bit = s_q.watchdog_kick_bit_en;
  assign watchdog_kick_bit_cnt_clr = cpu_rst || (halt_enter && !s_q.watchdog_kick_bit_en) || (misc_wr && misc_wdata[0]);
  assign tmr_preset = ric_pkg::TIMER_PRESET;  // [R19]
  assign tmr_reset = cpu_rst;
  assign port_dir_clr = cpu_rst;
  assign store_ctl_clr = cpu_rst;
  assign sp_reset_val = ric_pkg::SP_RESET;
  assign sp_load = cpu_rst;
  assign cpu_clk_en = !por_active && !s_q.halt && !s_q.waitl && !s_q.stop_gate;  // [R21]
  assign timer_clk_en = !por_active && !s_q.halt && !s_q.stop_gate;  // [R21]
  assign halt_latch = s_q.halt;
  assign wait_latch = s_q.waitl;

endmodule

// ==== verification/ric_top_sva.sv ====
// Purpose: Port-level checks
// Assumes: One clock
// Notes: Push c1..c5, vector c6
`timescale 1ns/10ps
module ric_top_sva (
  input wire logic clk_sys, // CPU clock
  input wire logic sys_rst, // Power-up detect
  input wire logic rst_pin_oe, // Pin pull-down
  input wire logic watchdog_kick_bit_rst_req, // Watchdog timeout
  input wire logic cpu_rst, // Internal reset
  input wire logic trap_exec, // Trap at boundary
  input wire logic instr_done, // Boundary pulse
  input wire logic irq_return_instruction, // Return pulse
  input wire logic [7:0] stack_cc_byte, // Popped codes
  input wire logic [15:0] program_counter, // Current PC
  input wire logic [7:0] stack_ptr_i, // Stack pointer
  input wire logic misc_wr, // Select write
  input wire logic [7:0] misc_wdata, // Select data
  input wire logic wait_enter, // Wait entry
  input wire logic push_valid, // Push strobe
  input wire logic [7:0] push_data, // Push byte
  input wire logic [7:0] push_sp, // Push address
  input wire logic pc_load, // Vector load
  input wire logic [12:0] vector_addr, // Vector
  input wire logic irq_busy, // Entry running
  input wire logic irq_mask, // Mask bit
  input wire logic ext_irq_rise_select, // Rise select
  input wire logic ext_irq_fall_select, // Fall select
  input wire logic [15:0] tmr_preset, // Timer preset
  input wire logic [7:0] sp_reset_val // Stack reset value
);
  // ****************************************
  // Clocking and disable
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // ****************************************
  // Properties
  // ****************************************
  property p_por_pull;
    $fell(sys_rst) |-> rst_pin_oe [*8];
  endproperty
  a_por_pull: assert property (p_por_pull) else $error("pin not pulled in power-on");
  property p_rst_vec;
    $fell(cpu_rst) |-> ##[0:1] (pc_load && vector_addr == ric_pkg::VEC_RESET);
  endproperty
  a_rst_vec: assert property (p_rst_vec) else $error("reset vector not loaded");
  property p_trap_entry;
    instr_done && trap_exec && !irq_busy && !cpu_rst
      |=> push_valid [*5] ##1 (pc_load && vector_addr == ric_pkg::VEC_TRAP);
  endproperty
  a_trap_entry: assert property (p_trap_entry) else $error("trap entry wrong");
  property p_push_first;
    instr_done && trap_exec && !irq_busy && !cpu_rst
      |=> push_data == 8'($past(program_counter)) && push_sp == $past(stack_ptr_i);
  endproperty
  a_push_first: assert property (p_push_first) else $error("first push wrong");
  property p_masked;
    instr_done && !irq_busy && irq_mask && !trap_exec && !cpu_rst |=> !push_valid [*6];
  endproperty
  a_masked: assert property (p_masked) else $error("masked source taken");
  property p_sel_ignored;
    misc_wr && !irq_mask && !irq_busy && !cpu_rst
      |=> $stable(ext_irq_rise_select) && $stable(ext_irq_fall_select);
  endproperty
  a_sel_ignored: assert property (p_sel_ignored) else $error("select changed unmasked");
  property p_sel_write;
    misc_wr && irq_mask && !irq_busy && !cpu_rst
      |=> {ext_irq_rise_select, ext_irq_fall_select} == 2'($past(misc_wdata) >> 5);
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("select bits misplaced");
  property p_ret_mask;
    irq_return_instruction && !irq_busy && !cpu_rst |=> irq_mask == 1'($past(stack_cc_byte) >> 3);
  endproperty
  a_ret_mask: assert property (p_ret_mask) else $error("mask not restored");
  property p_rst_vals;
    $fell(cpu_rst) |-> irq_mask && tmr_preset == 16'hFFFC && sp_reset_val == 8'hFF;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("reset values wrong");
  property p_wait_mask;
    wait_enter && !irq_busy && !cpu_rst |=> !irq_mask;
  endproperty
  a_wait_mask: assert property (p_wait_mask) else $error("wait kept mask");
  property p_watchdog_kick_bit_pin;
    watchdog_kick_bit_rst_req && !cpu_rst |-> ##[0:2] rst_pin_oe ##[1:12] cpu_rst;
  endproperty
  a_watchdog_kick_bit_pin: assert property (p_watchdog_kick_bit_pin) else $error("watchdog reset not via pin");
endmodule

// ==== verification/ric_partner.sv ====
// Purpose: Outside reset circuit sharing the open-drain reset line
// Assumes: Line has a pull-up; any party pulling low wins
// Notes: Holding time of the outside pull is set by the bench
`timescale 1ns/10ps
module ric_partner (
  input wire logic rst_pin_oe, // Device pull-down enable
  input wire logic rst_pin_o, // Device drive value
  input wire logic ext_hold, // Outside circuit pulls low
  output logic rst_pin_i // Resolved line level
);
  // Wired line: pull-up unless someone pulls down
  assign rst_pin_i = ((rst_pin_oe && !rst_pin_o) || ext_hold) ? 1'b0 : 1'b1;
endmodule

// ==== verification/ric_top_bench.sv ====
// Purpose: Self-checking bench
// Assumes: Inputs driven at negedge
// Notes: Full power-on hold
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fails++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module ric_top_bench;
  logic clk_sys, rst_pin_i, rst_pin_o, rst_pin_oe, cpu_rst, pc_load, irq_mask;
  logic sys_rst = 1, ext_hold = 1, watchdog_kick_bit_rst_req = 0, ext_irq_pin = 1, trap_exec = 0;
  logic instr_done = 0, irq_return_instruction = 0, misc_wr = 0, halt_enter = 0, wait_enter = 0;
  logic tmr_icap_irq = 0, tmr_ocmp_irq = 0, tmr_tovf_irq = 0;
  logic [5:0] wakeup_pins = 6'h3F, wakeup_irq_en = 6'h00;
  logic [7:0] stack_cc_byte = 8'h00, x_reg = 8'h00, acc_reg = 8'h00, cond_code_reg = 8'h00;
  logic [7:0] misc_wdata = 8'h00, stack_ptr_i = 8'hFF;
  logic [15:0] program_counter = 16'h0000;
  logic [12:0] vector_addr, wv;
  logic [12:0] exp_q[$]; // Vectors expected in order
  logic [12:0] vecs[6] = '{ric_pkg::VEC_TRAP, ric_pkg::VEC_EXT, ric_pkg::VEC_ICAP,
    ric_pkg::VEC_OCMP, ric_pkg::VEC_TOVF, ric_pkg::VEC_WAKE};
  int fails = 0, checked = 0;

  ric_top i_ric_top (
    .*,
    .push_valid(), .push_data(), .push_sp(), .irq_busy(), .ext_irq_rise_select(),
    .ext_irq_fall_select(), .slow_clock_select(), .watchdog_kick_bit(), .watchdog_kick_bit_cnt_clr(),
    .tmr_preset(), .tmr_reset(), .port_dir_clr(), .store_ctl_clr(), .sp_reset_val(),
    .sp_load(), .cpu_clk_en(), .timer_clk_en(), .halt_latch(), .wait_latch()
  );
  ric_partner i_ric_partner (.rst_pin_oe(rst_pin_oe), .rst_pin_o(rst_pin_o),
    .ext_hold(ext_hold), .rst_pin_i(rst_pin_i));

  // 25 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // Boundary after pins settle
  task automatic boundary(input logic trap, input logic [12:0] v, input logic hit);
    {x_reg, acc_reg, cond_code_reg, stack_ptr_i} = $urandom;
    program_counter = 16'($urandom);
    cyc(4);
    if (hit)
      exp_q.push_back(v);
    trap_exec = trap;
    instr_done = 1'b1;
    cyc(1);
    instr_done = 1'b0;
    trap_exec = 1'b0;
    cyc(8);
  endtask

  // Return with a chosen stacked mask
  task automatic ret(input logic m);
    stack_cc_byte = {4'($urandom), m, 3'($urandom)};
    irq_return_instruction = 1'b1;
    cyc(1);
    irq_return_instruction = 1'b0;
    `CHK("irq_mask", m, irq_mask)
    cyc(2);
  endtask

  // Set mode masked; retry unmasked
  task automatic setmode(input logic [1:0] m);
    boundary(1'b1, ric_pkg::VEC_TRAP, 1'b1);
    misc_wr = 1'b1;
    misc_wdata = {1'b0, m, 5'h00};
    cyc(1);
    misc_wr = 1'b0;
    ret(1'b0);
    misc_wr = 1'b1;
    misc_wdata = {1'b0, ~m, 5'h00};
    cyc(1);
    misc_wr = 1'b0;
  endtask

  task automatic print_verdict;
    if (fails == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Watcher: every vector load takes the oldest note
  always @(negedge clk_sys)
  begin
    if (pc_load === 1'b1)
    begin
      wv = (exp_q.size() != 0) ? exp_q.pop_front() : 13'h0000;
      `CHK("vector_addr", wv, vector_addr)
    end
  end

  // Hang guard
  initial
  begin
    repeat (30000) @(posedge clk_sys);
    fails++;
    print_verdict();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    void'($urandom(60190));
    cyc(20);
    sys_rst = 1'b0;
    exp_q.push_back(ric_pkg::VEC_RESET);
    cyc(100);
    `CHK("rst_pin_oe", 1'b1, rst_pin_oe)
    cyc(4100);
    `CHK("cpu_rst", 1'b1, cpu_rst)
    ext_hold = 1'b0;
    for (int k = 0; k < 50 && cpu_rst !== 1'b0; k++)
      cyc(1);
    `CHK("cpu_rst", 1'b0, cpu_rst)
    cyc(4);
    // Masked: trap only
    tmr_tovf_irq = 1'b1;
    boundary(1'b0, 13'h0000, 1'b0);
    boundary(1'b1, ric_pkg::VEC_TRAP, 1'b1);
    ret(1'b0);
    // Priority: sources i up to overflow pending; wake-up only at i = 5
    wakeup_irq_en = 6'($urandom) | 6'h01;
    for (int i = 0; i < 6; i++)
    begin
      ext_irq_pin = (i > 1);
      tmr_icap_irq = (i <= 2);
      tmr_ocmp_irq = (i <= 3);
      tmr_tovf_irq = (i <= 4);
      wakeup_pins = (i == 5) ? ~wakeup_irq_en : 6'h3F;
      boundary(i == 0, vecs[i], 1'b1);
      ret(1'b0);
    end
    wakeup_pins = 6'h3F;
    // Trigger modes
    for (int m = 0; m < 4; m++)
    begin
      setmode(2'(m));
      ext_irq_pin = 1'b0;
      boundary(1'b0, ric_pkg::VEC_EXT, m != 2);
      ret(1'b0);
      if (m == 0)
      begin
        boundary(1'b0, ric_pkg::VEC_EXT, 1'b1);
        ret(1'b0);
      end
      boundary(1'b1, ric_pkg::VEC_TRAP, 1'b1);
      ext_irq_pin = 1'b1;
      cyc(4);
      ret(1'b0);
      boundary(1'b0, ric_pkg::VEC_EXT, m >= 2);
      ret(1'b0);
    end
    // Wait entry clears the mask
    boundary(1'b1, ric_pkg::VEC_TRAP, 1'b1);
    wait_enter = 1'b1;
    cyc(1);
    wait_enter = 1'b0;
    `CHK("irq_mask", 1'b0, irq_mask)
    // Watchdog via pin
    exp_q.push_back(ric_pkg::VEC_RESET);
    watchdog_kick_bit_rst_req = 1'b1;
    cyc(1);
    watchdog_kick_bit_rst_req = 1'b0;
    cyc(60);
    `CHK("cpu_rst", 1'b0, cpu_rst)
    `CHK("exp_q", 0, exp_q.size())
    print_verdict();
  end
endmodule
bind ric_top ric_top_sva i_ric_top_sva (.*);
